// >>> design/uhtb_regs.sv
// token command, frame threshold and descriptor base registers behind AXI4-Lite
`timescale 1ns/10ps
module uhtb_regs #(
  parameter int FRAME_BITS = uhtb_pkg::FRAME_BITS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tx_start,
  output logic [3:0] tx_pid,
  output logic [3:0] tx_endp,
  output logic [6:0] tx_dev_addr,
  output logic tx_low_speed,
  input wire logic tx_done,
  output logic frame_start,
  output logic [31:0] descriptor_base
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [3:0] token_type_field_r;
  logic [3:0] token_endpoint_field_r;
  logic [7:0] frame_threshold_count_r;
  logic [6:0] descriptor_base_low_bits_r;
  logic [7:0] descriptor_base_mid_bits_r;
  logic [7:0] descriptor_base_high_bits_r;
  logic next_token_low_speed_r;
  logic [6:0] dev_addr_r;
  logic host_en_r;
  logic token_busy_r;
  uhtb_pkg::uhtb_tok_state_t tok_state_r;
  uhtb_pkg::uhtb_tok_state_t tok_state_nxt;

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  logic aw_full_r;
  logic w_full_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic wr_mapped;
  logic lane0;

  // awprot and arprot carry no meaning here
  assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
  assign lane0 = w_strb_r[0];

  always_comb begin
    wr_mapped = 1'b0;
    case (aw_addr_r)
      uhtb_pkg::OFS_TOKEN, uhtb_pkg::OFS_SOF, uhtb_pkg::OFS_BASE_ONE,
      uhtb_pkg::OFS_BASE_TWO, uhtb_pkg::OFS_BASE_THREE, uhtb_pkg::OFS_ADDR,
      uhtb_pkg::OFS_CTRL: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_full_r <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_full_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uhtb_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? uhtb_pkg::RESP_OKAY : uhtb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  logic wr_token;
  logic wr_sof;
  logic wr_one;
  logic wr_two;
  logic wr_three;
  logic wr_addr;
  logic wr_ctrl;

  assign wr_token = wr_fire && lane0 && (aw_addr_r == uhtb_pkg::OFS_TOKEN);
  assign wr_sof = wr_fire && lane0 && (aw_addr_r == uhtb_pkg::OFS_SOF);
  assign wr_one = wr_fire && lane0 && (aw_addr_r == uhtb_pkg::OFS_BASE_ONE);
  assign wr_two = wr_fire && lane0 && (aw_addr_r == uhtb_pkg::OFS_BASE_TWO);
  assign wr_three = wr_fire && lane0 && (aw_addr_r == uhtb_pkg::OFS_BASE_THREE);
  assign wr_addr = wr_fire && lane0 && (aw_addr_r == uhtb_pkg::OFS_ADDR);
  assign wr_ctrl = wr_fire && lane0 && (aw_addr_r == uhtb_pkg::OFS_CTRL);

  // only bits 7:0 are stored anywhere, upper lanes fall away
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      token_type_field_r <= uhtb_pkg::RST_NIBBLE;
      token_endpoint_field_r <= uhtb_pkg::RST_NIBBLE;
    end else if (wr_token && !token_busy_r) begin
      // a write while busy is dropped so the launched token stays stable
      token_type_field_r <= w_data_r[uhtb_pkg::TOK_PID_MSB:uhtb_pkg::TOK_PID_LSB];
      token_endpoint_field_r <= w_data_r[uhtb_pkg::TOK_EP_MSB:uhtb_pkg::TOK_EP_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_threshold_count_r <= uhtb_pkg::RST_BYTE;
    end else if (wr_sof) begin
      frame_threshold_count_r <= w_data_r[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      descriptor_base_low_bits_r <= uhtb_pkg::RST_SEVEN;
      descriptor_base_mid_bits_r <= uhtb_pkg::RST_BYTE;
      descriptor_base_high_bits_r <= uhtb_pkg::RST_BYTE;
    end else begin
      if (wr_one) begin
        descriptor_base_low_bits_r <=
          w_data_r[uhtb_pkg::BASE_ONE_MSB:uhtb_pkg::BASE_ONE_LSB];
      end
      if (wr_two) begin
        descriptor_base_mid_bits_r <= w_data_r[7:0];
      end
      if (wr_three) begin
        descriptor_base_high_bits_r <= w_data_r[7:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_token_low_speed_r <= 1'b0;
      dev_addr_r <= uhtb_pkg::RST_SEVEN;
      host_en_r <= 1'b0;
    end else begin
      if (wr_addr) begin
        next_token_low_speed_r <= w_data_r[uhtb_pkg::ADDR_LS_BIT];
        dev_addr_r <= w_data_r[uhtb_pkg::ADDR_DEV_MSB:0];
      end
      if (wr_ctrl) begin
        host_en_r <= w_data_r[uhtb_pkg::CTRL_HOST_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      descriptor_base <= 32'h0000_0000;
    end else begin
      descriptor_base <= {descriptor_base_high_bits_r, descriptor_base_mid_bits_r,
                          descriptor_base_low_bits_r, uhtb_pkg::BASE_ALIGN_ZERO};
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  logic [31:0] rd_word;
  logic rd_mapped;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      uhtb_pkg::OFS_TOKEN: rd_word[7:0] = {token_type_field_r, token_endpoint_field_r};
      uhtb_pkg::OFS_SOF: rd_word[7:0] = frame_threshold_count_r;
      uhtb_pkg::OFS_BASE_ONE: rd_word[7:0] = {descriptor_base_low_bits_r, 1'b0};
      uhtb_pkg::OFS_BASE_TWO: rd_word[7:0] = descriptor_base_mid_bits_r;
      uhtb_pkg::OFS_BASE_THREE: rd_word[7:0] = descriptor_base_high_bits_r;
      uhtb_pkg::OFS_ADDR: rd_word[7:0] = {next_token_low_speed_r, dev_addr_r};
      uhtb_pkg::OFS_CTRL: begin
        rd_word[uhtb_pkg::CTRL_HOST_BIT] = host_en_r;
        rd_word[uhtb_pkg::CTRL_BUSY_BIT] = token_busy_r;
        rd_word[uhtb_pkg::CTRL_PEND_BIT] = (tok_state_r == uhtb_pkg::TOK_WAIT_ROOM);
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= uhtb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? uhtb_pkg::RESP_OKAY : uhtb_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // frame timing
  // ****************************************************************
  logic [uhtb_pkg::BITS_W-1:0] bits_left;
  logic frame_pulse;
  logic room_ok;

  uhtb_frame_timer #(
    .FRAME_BITS(FRAME_BITS)
  ) u_frame (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(host_en_r),
    .bits_left(bits_left),
    .frame_start(frame_pulse)
  );

  // the start-of-frame slot itself is never used for a token
  assign room_ok = !frame_pulse &&
                   (bits_left >= {6'h00, frame_threshold_count_r});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_start <= 1'b0;
    end else begin
      frame_start <= frame_pulse;
    end
  end

  // ****************************************************************
  // token engine
  // ****************************************************************
  logic launch;

  assign launch = (tok_state_r == uhtb_pkg::TOK_WAIT_ROOM) && host_en_r && room_ok;

  always_comb begin
    tok_state_nxt = tok_state_r;
    case (tok_state_r)
      uhtb_pkg::TOK_IDLE: begin
        if (wr_token) begin
          tok_state_nxt = uhtb_pkg::TOK_WAIT_ROOM;
        end
      end
      uhtb_pkg::TOK_WAIT_ROOM: begin
        if (launch) begin
          tok_state_nxt = uhtb_pkg::TOK_ACTIVE;
        end
      end
      uhtb_pkg::TOK_ACTIVE: begin
        if (tx_done) begin
          tok_state_nxt = uhtb_pkg::TOK_IDLE;
        end
      end
      default: tok_state_nxt = uhtb_pkg::TOK_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tok_state_r <= uhtb_pkg::TOK_IDLE;
      token_busy_r <= 1'b0;
    end else begin
      tok_state_r <= tok_state_nxt;
      token_busy_r <= (tok_state_nxt != uhtb_pkg::TOK_IDLE);
    end
  end

  // token type passes through unchanged; codes 1101/1001/0001 name SETUP/IN/OUT
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_start <= 1'b0;
      tx_pid <= uhtb_pkg::RST_NIBBLE;
      tx_endp <= uhtb_pkg::RST_NIBBLE;
      tx_dev_addr <= uhtb_pkg::RST_SEVEN;
      tx_low_speed <= 1'b0;
    end else begin
      tx_start <= launch;
      if (launch) begin
        tx_pid <= token_type_field_r;
        tx_endp <= token_endpoint_field_r;
        tx_dev_addr <= dev_addr_r;
        tx_low_speed <= next_token_low_speed_r;
      end
    end
  end

endmodule : uhtb_regs

// >>> common/uhtb_pkg.sv
// constants, field layout and types of the token and descriptor base register bank
// ****************************************************************
// Notes on behaviour
// - The token type field codes SETUP as 1101, IN as 1001 and OUT as 0001.
// - The token command register holds the token type in bits 7-4 and the endpoint in 3-0, both read/write.
// - The frame threshold is an 8-bit read/write count, typically 0x4A, 0x2A, 0x1A or 0x12 by packet size.
// - Bits 7-1 of page one hold base address bits 15:9 and bit 0 of page one reads zero.
// - Page two holds base address bits 23:16.
// - The base is 512-byte aligned, so its bits 8:0 are always zero.
// - Bits 31-8 of these registers read zero and ignore writes.
// - Every implemented field resets to zero.
// - Page three holds base address bits 31:24 and completes the 32-bit base.
// - The low speed bit of the address register selects low or full speed for the next token.
// ****************************************************************
package uhtb_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [31:0] OFS_TOKEN = 32'h0000_0000;
  localparam logic [31:0] OFS_SOF = 32'h0000_0004;
  localparam logic [31:0] OFS_BASE_ONE = 32'h0000_0008;
  localparam logic [31:0] OFS_BASE_TWO = 32'h0000_000C;
  localparam logic [31:0] OFS_BASE_THREE = 32'h0000_0010;
  localparam logic [31:0] OFS_ADDR = 32'h0000_0014;
  localparam logic [31:0] OFS_CTRL = 32'h0000_0018;
  localparam int DEC_MSB = 4;
  localparam int DEC_LSB = 2;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int TOK_PID_MSB = 7;
  localparam int TOK_PID_LSB = 4;
  localparam int TOK_EP_MSB = 3;
  localparam int TOK_EP_LSB = 0;
  localparam logic [3:0] PID_SETUP = 4'hD;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [7:0] SOF_THR_64 = 8'h4A;
  localparam logic [7:0] SOF_THR_32 = 8'h2A;
  localparam logic [7:0] SOF_THR_16 = 8'h1A;
  localparam logic [7:0] SOF_THR_8 = 8'h12;
  localparam int BASE_ONE_MSB = 7;
  localparam int BASE_ONE_LSB = 1;
  localparam int ADDR_LS_BIT = 7;
  localparam int ADDR_DEV_MSB = 6;
  localparam int CTRL_HOST_BIT = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_PEND_BIT = 2;
  localparam logic [8:0] BASE_ALIGN_ZERO = 9'h000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_SEVEN = 7'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLOCK_MHZ = 10;
  localparam int BIT_RATE_MHZ = 12;
  localparam int FRAME_TIME_US = 1000;
  localparam int FRAME_BITS = FRAME_TIME_US * BIT_RATE_MHZ;
  // cycles between the extra bit time that keeps the count at bit rate
  localparam int EXTRA_BIT_CYCLES = CLOCK_MHZ / (BIT_RATE_MHZ - CLOCK_MHZ);
  localparam int BITS_W = 14;

  typedef enum logic [1:0] {
    TOK_IDLE,
    TOK_WAIT_ROOM,
    TOK_ACTIVE
  } uhtb_tok_state_t;

endpackage : uhtb_pkg

// >>> design/uhtb_frame_timer.sv
// frame bit-time down counter with start-of-frame pulse
`timescale 1ns/10ps
module uhtb_frame_timer #(
  parameter int FRAME_BITS = uhtb_pkg::FRAME_BITS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic [uhtb_pkg::BITS_W-1:0] bits_left,
  output logic frame_start
);

  localparam logic [uhtb_pkg::BITS_W-1:0] RELOAD = uhtb_pkg::BITS_W'(FRAME_BITS);
  localparam logic [2:0] EXTRA_LAST = 3'(uhtb_pkg::EXTRA_BIT_CYCLES - 1);
  localparam logic [uhtb_pkg::BITS_W-1:0] ONE = 14'h0001;
  localparam logic [uhtb_pkg::BITS_W-1:0] TWO = 14'h0002;

  logic [2:0] div_r;
  logic extra;
  logic [uhtb_pkg::BITS_W-1:0] step;

  // clock is slower than the bit rate, so some cycles take two bit times
  assign extra = (div_r == EXTRA_LAST);
  assign step = extra ? TWO : ONE;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_r <= 3'h0;
    end else if (extra) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      bits_left <= RELOAD;
      frame_start <= 1'b0;
    end else if (bits_left <= step) begin
      bits_left <= RELOAD;
      frame_start <= 1'b1;
    end else begin
      bits_left <= bits_left - step;
      frame_start <= 1'b0;
    end
  end

endmodule : uhtb_frame_timer

// >>> sim/uhtb_regs_assertions.sv
// port checker for the token and descriptor base register bank
`timescale 1ns/10ps
module uhtb_regs_checker #(
  parameter int FRAME_BITS = 300
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tx_start,
  input wire logic [3:0] tx_pid,
  input wire logic [3:0] tx_endp,
  input wire logic [6:0] tx_dev_addr,
  input wire logic tx_low_speed,
  input wire logic tx_done,
  input wire logic frame_start,
  input wire logic [31:0] descriptor_base
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // helper: a transaction is on the line
  // ****************************************
  logic active_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) active_r <= 1'b0;
    else if (tx_start) active_r <= 1'b1;
    else if (tx_done) active_r <= 1'b0;
  end
  sequence s_launch; tx_start; endsequence
  sequence s_quiet; !tx_start [*2]; endsequence
  property p_pulse; s_launch |=> s_quiet; endproperty
  property p_one_at_a_time; s_launch |-> !active_r; endproperty
  property p_fields;
    !tx_start |-> $stable({tx_pid, tx_endp, tx_dev_addr, tx_low_speed});
  endproperty
  property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_align; descriptor_base[8:0] == uhtb_pkg::BASE_ALIGN_ZERO; endproperty
  property p_base_src;
    $changed(descriptor_base) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  property p_rst; $rose(aresetn) |-> descriptor_base == 32'h0 && !tx_start; endproperty
  // frames are hundreds of cycles long, so a pulse is always followed by quiet
  property p_frame_pulse; frame_start |=> !frame_start [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("launch pulse too long");
  a_one_at_a_time: assert property (p_one_at_a_time) else $error("launch while busy");
  a_fields: assert property (p_fields) else $error("token fields moved");
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_align: assert property (p_align) else $error("base not aligned");
  a_base_src: assert property (p_base_src) else $error("base moved unwritten");
  a_rst: assert property (p_rst) else $error("reset value wrong");
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse too long");
endmodule : uhtb_regs_checker

bind uhtb_regs uhtb_regs_checker #(.FRAME_BITS(FRAME_BITS)) uhtb_regs_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .tx_start(tx_start), .tx_pid(tx_pid), .tx_endp(tx_endp), .tx_dev_addr(tx_dev_addr),
  .tx_low_speed(tx_low_speed), .tx_done(tx_done), .frame_start(frame_start),
  .descriptor_base(descriptor_base));

// >>> sim/uhtb_line_model.sv
// line logic stand-in: ends each launched transaction after a delay
`timescale 1ns/10ps
module uhtb_line_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_start,
  input wire logic slow,
  output logic tx_done
);
  logic [7:0] cnt_r;
  // slow answers keep the engine busy long enough to try a second token
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 8'h00;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (cnt_r == 8'h01);
      if (tx_start) cnt_r <= slow ? 8'h3C : 8'h03;
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : uhtb_line_model

// >>> sim/tb.sv
// register and token tests for the register bank
`timescale 1ns/10ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, v;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_start, tx_low_speed, tx_done, frame_start;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, descriptor_base;
  logic [3:0] tx_pid, tx_endp;
  logic [6:0] tx_dev_addr;
  logic [3:0] pids [3];
  logic [7:0] thr [4];
  int error_cnt = 0, check_count = 0, starts = 0, rd_lag = 0;
  uhtb_regs #(.FRAME_BITS(300)) uhtb_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_start(tx_start), .tx_pid(tx_pid), .tx_endp(tx_endp),
    .tx_dev_addr(tx_dev_addr), .tx_low_speed(tx_low_speed), .tx_done(tx_done),
    .frame_start(frame_start), .descriptor_base(descriptor_base));
  uhtb_line_model uhtb_line_model_inst (.aclk(aclk), .aresetn(aresetn), .tx_start(tx_start),
    .slow(slow), .tx_done(tx_done));
  always #50 aclk = ~aclk;
  always @(posedge aclk) if (tx_start === 1'b1) starts <= starts + 1;
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // sampling at the falling edge keeps handshakes clear of the design's own updates
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] rs);
    int n = 0;
    logic ah = 1'b0, wh = 1'b0, hs = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!hs && n < 200) begin
      @(negedge aclk);
      ah = awvalid && awready; wh = wvalid && wready; hs = bvalid && bready; rs = bresp;
      @(posedge aclk);
      n++;
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (hs) bready <= 1'b0;
    end
    if (!hs) chk(32'h0, 32'h1);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n = 0;
    logic ah = 1'b0, hs = 1'b0;
    @(posedge aclk);
    // a late rready makes the design hold its read answer for a few cycles
    araddr <= a; arvalid <= 1'b1; rready <= (rd_lag == 0);
    while (!hs && n < 200) begin
      @(negedge aclk);
      ah = arvalid && arready; hs = rvalid && rready; d = rdata; rs = rresp;
      @(posedge aclk);
      n++;
      if (ah) arvalid <= 1'b0;
      if (hs) rready <= 1'b0;
      else if (n >= rd_lag) rready <= 1'b1;
    end
    if (!hs) chk(32'h0, 32'h1);
  endtask : rd
  task automatic wait_idle();
    int n = 0;
    v = 32'h2;
    while (v[uhtb_pkg::CTRL_BUSY_BIT] !== 1'b0 && n < 200) begin
      rd(uhtb_pkg::OFS_CTRL, v, r);
      n++;
    end
    chk({31'h0, v[uhtb_pkg::CTRL_BUSY_BIT]}, 32'h0);
  endtask : wait_idle
  // ****************************************
  // tests
  // ****************************************
  initial begin
    pids[0] = uhtb_pkg::PID_SETUP; pids[1] = uhtb_pkg::PID_IN; pids[2] = uhtb_pkg::PID_OUT;
    thr[0] = uhtb_pkg::SOF_THR_64; thr[1] = uhtb_pkg::SOF_THR_32;
    thr[2] = uhtb_pkg::SOF_THR_16; thr[3] = uhtb_pkg::SOF_THR_8;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(32'(4 * i), v, r);
      chk(v, 32'h0);
    end
    chk(descriptor_base, 32'h0);
    rd(32'h0000_0020, v, r);
    chk({30'h0, r}, {30'h0, uhtb_pkg::RESP_SLVERR});
    chk(v, 32'h0);
    wr(32'h0000_0040, 32'hFFFF_FFFF, 4'hF, r);
    chk({30'h0, r}, {30'h0, uhtb_pkg::RESP_SLVERR});
    wr(uhtb_pkg::OFS_SOF, 32'hFFFF_FFFF, 4'hF, r);
    rd_lag = 3;
    rd(uhtb_pkg::OFS_SOF, v, r);
    rd_lag = 0;
    chk(v, 32'h0000_00FF);
    for (int i = 0; i < 4; i++) begin
      wr(uhtb_pkg::OFS_SOF, {24'h0, thr[i]}, 4'hF, r);
      rd(uhtb_pkg::OFS_SOF, v, r);
      chk(v, {24'h0, thr[i]});
    end
    wr(uhtb_pkg::OFS_SOF, 32'h0000_0055, 4'h0, r);
    rd(uhtb_pkg::OFS_SOF, v, r);
    chk(v, 32'h0000_0012);
    wr(uhtb_pkg::OFS_BASE_ONE, 32'hFFFF_FFFF, 4'hF, r);
    rd(uhtb_pkg::OFS_BASE_ONE, v, r);
    chk(v, 32'h0000_00FE);
    wr(uhtb_pkg::OFS_BASE_TWO, 32'h1234_56A5, 4'hF, r);
    rd(uhtb_pkg::OFS_BASE_TWO, v, r);
    chk(v, 32'h0000_00A5);
    wr(uhtb_pkg::OFS_BASE_THREE, 32'h0000_003C, 4'hF, r);
    rd(uhtb_pkg::OFS_BASE_THREE, v, r);
    chk(v, 32'h0000_003C);
    chk(descriptor_base, 32'h3CA5_FE00);
    wr(uhtb_pkg::OFS_CTRL, 32'h0000_0001, 4'hF, r);
    for (int i = 0; i < 3; i++) begin
      slow <= (i == 0);
      wr(uhtb_pkg::OFS_ADDR, {24'h0, i[0], 7'h05}, 4'hF, r);
      wait_idle();
      wr(uhtb_pkg::OFS_TOKEN, {24'h0, pids[i], 4'(i + 2)}, 4'hF, r);
      chk({30'h0, r}, {30'h0, uhtb_pkg::RESP_OKAY});
      for (int k = 0; k < 600 && starts == i; k++) @(posedge aclk);
      chk(32'(starts), 32'(i + 1));
      chk({16'h0, tx_pid, tx_endp, tx_dev_addr, tx_low_speed},
          {16'h0, pids[i], 4'(i + 2), 7'h05, i[0]});
      if (i == 0) begin
        wr(uhtb_pkg::OFS_TOKEN, 32'h0000_0011, 4'hF, r);
      end
      rd(uhtb_pkg::OFS_TOKEN, v, r);
      chk(v, {24'h0, pids[i], 4'(i + 2)});
      wait_idle();
    end
    for (int k = 0; k < 600 && frame_start !== 1'b1; k++) @(posedge aclk);
    chk({31'h0, frame_start}, 32'h1);
    chk(32'(starts), 32'h3);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    conclude();
  end
endmodule : tb
